// [tcc_checker.sv]
// concurrent checks on the test and assessment control register bank
`timescale 1ns/1ps
module tcc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] test_bus_in,
  input wire logic antenna_dwell_interval,
  input wire logic raw_channel_clear,
  input wire logic [4:0] auto_cal_bits,
  input wire logic [5:0] adc_rssi,
  input wire logic [2:0] adc_i,
  input wire logic [2:0] adc_q,
  input wire logic [2:0] tx_i,
  input wire logic [7:0] test_bus_address,
  input wire logic pn_gen_enable,
  input wire logic path_selector_alt,
  input wire logic high_rate_xor_to_test_bus,
  input wire logic [4:0] cal_bits,
  input wire logic [11:0] adc_raw_pins,
  input wire logic adc_raw_pins_enable,
  input wire logic modem_disable,
  input wire logic [2:0] rx_i,
  input wire logic energy_detect_enable,
  input wire logic energy_detect_update,
  input wire logic channel_clear_assessment
);
  logic up_q;
  logic wr;
  logic [7:0] sel_q, en1_q, en2_q, cv_q;
  assign wr = psel && penable && pready && pwrite;
  // shadows rebuilt from bus writes, so no peeking into the body
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      up_q <= 1'b0;
      sel_q <= 8'h00;
      en1_q <= 8'h00;
      en2_q <= 8'h00;
      cv_q <= 8'h00;
    end
    else
    begin
      up_q <= 1'b1;
      if (wr && paddr == 8'h70) sel_q <= pwdata[7:0];
      if (wr && paddr == 8'h78) en1_q <= pwdata[7:0];
      if (wr && paddr == 8'h7C) en2_q <= pwdata[7:0];
      if (wr && paddr == 8'h0C) cv_q <= pwdata[7:0];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_CTRL: assert property (up_q |-> {pn_gen_enable, path_selector_alt,
    high_rate_xor_to_test_bus} == $past(en1_q[7:5])) else $error("control bits wrong");
  AST_RAW: assert property (up_q |-> {adc_raw_pins_enable, modem_disable, adc_raw_pins} ==
    $past(en1_q[1] ? {2'h3, adc_rssi, adc_i, adc_q} : 14'h0)) else $error("raw pins wrong");
  AST_CAL: assert property (up_q |-> cal_bits ==
    $past(en1_q[2] ? cv_q[4:0] : auto_cal_bits)) else $error("cal bits wrong");
  AST_LOOP: assert property (up_q |-> rx_i == $past(en1_q[0] ? tx_i : adc_i))
    else $error("receive i wrong");
  AST_ADDR: assert property (up_q && !$past(en1_q[4]) |-> test_bus_address == $past(sel_q))
    else $error("test bus address wrong");
  AST_RB: assert property (pready && !pwrite && paddr == 8'h74 |->
    prdata == {24'h0, $past(test_bus_in)}) else $error("readback wrong");
  AST_ERR: assert property (pready |->
    pslverr == !(paddr inside {8'h70, 8'h74, 8'h78, 8'h7C, 8'h0C})) else $error("bad error");
  AST_REG: assert property (pready && !pwrite && paddr == 8'h78 |->
    prdata == {24'h0, en1_q}) else $error("enables readback wrong");
  AST_CCA: assert property (!en2_q[0] && !$past(en2_q[0]) && antenna_dwell_interval |=>
    channel_clear_assessment == $past(raw_channel_clear)) else $error("raw cca wrong");
  AST_EDC: assert property (en2_q[1] && $past(en2_q[1]) |=> energy_detect_enable &&
    energy_detect_update == $past(antenna_dwell_interval)) else $error("ed run wrong");
endmodule
bind test_and_cca_control_registers tcc_checker chk (.*);

// [test_and_cca_control_registers.sv]
// apb register bank for test enables, calibration override and channel assessment control
// Notes on behaviour
// - readback register returns the eight selected test bus levels, bit n is output n
// - enables bit 7 turns on the fault-test pseudo-noise generator
// - enables bit 6 switches the subsample path selector to its alternate setting
// - enables bit 5 routes high rate demodulator xor data onto the test bus
// - enables bit 4 drives a random address onto the test bus selection
// - enables bit 3 raises the calibration update clock from 1kHz to 22kHz
// - enables bit 2 takes the five calibration bits from the calibration value register
// - enables bit 1 puts all twelve converter bits on pins and stops the modem
// - enables bit 0 loops transmit i and q into the receive inputs, bypassing converters
// - second register bits 7 to 2 are plain storage with no internal effect
// - energy detect stops 19us after receive enable, or runs on every dwell interval
// - channel assessment is raw per dwell interval, or a latched snapshot
// - test bus select register at 70h supplies the test bus address while enables bit 4 is clear
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

module test_and_cca_control_registers #(
  parameter int CAL_SLOW_PERIOD = test_cca_pkg::CAL_SLOW_CYCLES,
  parameter int TEST_BUS_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TEST_BUS_WIDTH-1:0] test_bus_in,
  input wire logic receive_enable,
  input wire logic antenna_dwell_interval,
  input wire logic raw_channel_clear,
  input wire logic [4:0] auto_cal_bits,
  input wire logic [5:0] adc_rssi,
  input wire logic [2:0] adc_i,
  input wire logic [2:0] adc_q,
  input wire logic [2:0] tx_i,
  input wire logic [2:0] tx_q,
  output logic [7:0] test_bus_address,
  output logic pn_gen_enable,
  output logic path_selector_alt,
  output logic high_rate_xor_to_test_bus,
  output logic cal_update_tick,
  output logic [4:0] cal_bits,
  output logic [11:0] adc_raw_pins,
  output logic adc_raw_pins_enable,
  output logic modem_disable,
  output logic [2:0] rx_i,
  output logic [2:0] rx_q,
  output logic energy_detect_enable,
  output logic energy_detect_update,
  output logic channel_clear_assessment
);

  logic [7:0] test_bus_select_q;
  logic [7:0] test_enables_one_q;
  logic [7:0] test_enables_two_q;
  logic [7:0] cal_value_q;
  logic [7:0] lfsr_q;
  logic [15:0] cal_count_q;
  logic [15:0] cal_period;
  logic [9:0] ed_count_q;
  logic rx_en_meta_q;
  logic rx_en_sync_q;
  logic rx_en_prev_q;
  logic rx_en_rise;
  logic snapshot_armed_q;
  logic access;
  logic wr_en;
  logic [31:0] rd_d;
  logic hit_d;

  // address decode shared by write enable and error answer
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == test_cca_pkg::ADDR_TEST_BUS_SELECT) ||
                (addr == test_cca_pkg::ADDR_TEST_BUS_READBACK) ||
                (addr == test_cca_pkg::ADDR_TEST_ENABLES_ONE) ||
                (addr == test_cca_pkg::ADDR_TEST_ENABLES_TWO) ||
                (addr == test_cca_pkg::ADDR_CAL_VALUE);
  endfunction

  // one wait state: pready rises in the second access cycle, writes land on that edge
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && is_mapped(paddr);

  always_comb
  begin
    rd_d = 32'h0000_0000;
    hit_d = is_mapped(paddr);
    unique case (paddr)
      test_cca_pkg::ADDR_TEST_BUS_SELECT: rd_d[7:0] = test_bus_select_q;
      test_cca_pkg::ADDR_TEST_BUS_READBACK: rd_d[TEST_BUS_WIDTH-1:0] = test_bus_in;
      test_cca_pkg::ADDR_TEST_ENABLES_ONE: rd_d[7:0] = test_enables_one_q;
      test_cca_pkg::ADDR_TEST_ENABLES_TWO: rd_d[7:0] = test_enables_two_q;
      test_cca_pkg::ADDR_CAL_VALUE: rd_d[7:0] = cal_value_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !hit_d;
      if (access && !pwrite)
      begin
        prdata <= rd_d;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      test_bus_select_q <= test_cca_pkg::RST_TEST_BUS_SELECT;
      test_enables_one_q <= test_cca_pkg::RST_TEST_ENABLES_ONE;
      test_enables_two_q <= test_cca_pkg::RST_TEST_ENABLES_TWO;
      cal_value_q <= test_cca_pkg::RST_CAL_VALUE;
    end
    else if (wr_en)
    begin
      if (paddr == test_cca_pkg::ADDR_TEST_BUS_SELECT)
      begin
        test_bus_select_q <= pwdata[7:0];
      end
      if (paddr == test_cca_pkg::ADDR_TEST_ENABLES_ONE)
      begin
        test_enables_one_q <= pwdata[7:0];
      end
      // upper bits are kept only for readback
      if (paddr == test_cca_pkg::ADDR_TEST_ENABLES_TWO)
      begin
        test_enables_two_q <= pwdata[7:0];
      end
      if (paddr == test_cca_pkg::ADDR_CAL_VALUE)
      begin
        cal_value_q <= pwdata[7:0];
      end
    end
  end

  // free running lfsr gives the random test bus address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lfsr_q <= test_cca_pkg::RST_LFSR;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      test_bus_address <= 8'h00;
      pn_gen_enable <= 1'b0;
      path_selector_alt <= 1'b0;
      high_rate_xor_to_test_bus <= 1'b0;
    end
    else
    begin
      if (test_enables_one_q[test_cca_pkg::BIT_RANDOM_ADDR])
      begin
        test_bus_address <= lfsr_q;
      end
      else
      begin
        test_bus_address <= test_bus_select_q;
      end
      pn_gen_enable <= test_enables_one_q[test_cca_pkg::BIT_PN_GEN];
      path_selector_alt <= test_enables_one_q[test_cca_pkg::BIT_PATH_SELECTOR];
      high_rate_xor_to_test_bus <= test_enables_one_q[test_cca_pkg::BIT_HR_XOR];
    end
  end

  // calibration update clock as a one-cycle enable; a rate change keeps the count running, so the first tick can come early
  always_comb
  begin
    if (test_enables_one_q[test_cca_pkg::BIT_FAST_CAL])
    begin
      cal_period = 16'(test_cca_pkg::CAL_FAST_CYCLES);
    end
    else
    begin
      cal_period = 16'(CAL_SLOW_PERIOD);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cal_count_q <= 16'h0000;
      cal_update_tick <= 1'b0;
    end
    else
    begin
      if (cal_count_q >= cal_period - 16'h0001)
      begin
        cal_count_q <= 16'h0000;
        cal_update_tick <= 1'b1;
      end
      else
      begin
        cal_count_q <= cal_count_q + 16'h0001;
        cal_update_tick <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cal_bits <= 5'h00;
    end
    else if (test_enables_one_q[test_cca_pkg::BIT_CAL_OVERRIDE])
    begin
      cal_bits <= cal_value_q[test_cca_pkg::CAL_BITS-1:0];
    end
    else
    begin
      cal_bits <= auto_cal_bits;
    end
  end

  // raw converter mode: modem is held off while the converters drive the pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adc_raw_pins <= 12'h000;
      adc_raw_pins_enable <= 1'b0;
      modem_disable <= 1'b0;
    end
    else
    begin
      adc_raw_pins_enable <= test_enables_one_q[test_cca_pkg::BIT_ADC_RAW];
      modem_disable <= test_enables_one_q[test_cca_pkg::BIT_ADC_RAW];
      if (test_enables_one_q[test_cca_pkg::BIT_ADC_RAW])
      begin
        adc_raw_pins <= {adc_rssi, adc_i, adc_q};
      end
      else
      begin
        adc_raw_pins <= 12'h000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_i <= 3'h0;
      rx_q <= 3'h0;
    end
    else if (test_enables_one_q[test_cca_pkg::BIT_LOOPBACK])
    begin
      rx_i <= tx_i;
      rx_q <= tx_q;
    end
    else
    begin
      rx_i <= adc_i;
      rx_q <= adc_q;
    end
  end

  // receive enable is a pin: synchronise before edge detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_en_meta_q <= 1'b0;
      rx_en_sync_q <= 1'b0;
      rx_en_prev_q <= 1'b0;
    end
    else
    begin
      rx_en_meta_q <= receive_enable;
      rx_en_sync_q <= rx_en_meta_q;
      rx_en_prev_q <= rx_en_sync_q;
    end
  end

  assign rx_en_rise = rx_en_sync_q && !rx_en_prev_q;

  // window counter counts down from the rising edge of receive enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ed_count_q <= 10'h000;
    end
    else if (rx_en_rise)
    begin
      ed_count_q <= 10'(test_cca_pkg::ED_WINDOW_CYCLES);
    end
    else if (ed_count_q != 10'h000)
    begin
      ed_count_q <= ed_count_q - 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      energy_detect_enable <= 1'b0;
      energy_detect_update <= 1'b0;
    end
    else if (test_enables_two_q[test_cca_pkg::BIT_ED_CONTINUOUS])
    begin
      energy_detect_enable <= 1'b1;
      energy_detect_update <= antenna_dwell_interval;
    end
    else
    begin
      energy_detect_enable <= rx_en_rise || (ed_count_q > 10'h001);
      energy_detect_update <= antenna_dwell_interval && (ed_count_q != 10'h000);
    end
  end

  // snapshot takes the first dwell result after each receive enable and holds it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      snapshot_armed_q <= 1'b0;
      channel_clear_assessment <= 1'b0;
    end
    else if (test_enables_two_q[test_cca_pkg::BIT_CCA_SNAPSHOT])
    begin
      if (snapshot_armed_q && antenna_dwell_interval)
      begin
        channel_clear_assessment <= raw_channel_clear;
        snapshot_armed_q <= rx_en_rise;
      end
      else if (rx_en_rise)
      begin
        snapshot_armed_q <= 1'b1;
      end
    end
    else
    begin
      snapshot_armed_q <= rx_en_rise;
      if (antenna_dwell_interval)
      begin
        channel_clear_assessment <= raw_channel_clear;
      end
    end
  end
endmodule

// [test_and_cca_control_registers_tb_top.sv]
// self-checking bench for the test and assessment control registers
`timescale 1ns/1ps
module test_and_cca_control_registers_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic receive_enable = 0, antenna_dwell_interval = 0, raw_channel_clear = 0;
  logic pn_gen_enable, path_selector_alt, high_rate_xor_to_test_bus, cal_update_tick;
  logic adc_raw_pins_enable, modem_disable, energy_detect_enable, energy_detect_update;
  logic channel_clear_assessment;
  logic [7:0] paddr = 8'h00, test_bus_in = 8'h00, test_bus_address, t;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [4:0] auto_cal_bits, cal_bits;
  logic [5:0] adc_rssi;
  logic [2:0] adc_i, adc_q, tx_i, tx_q, rx_i, rx_q;
  logic [4:0] v;
  logic [11:0] adc_raw_pins;
  logic [22:0] stim_q = 23'h0, lag_q = 23'h0;
  int err_count = 0, check_count = 0, n;
  // converter and transmit inputs keep moving so stale paths show up
  assign {adc_rssi, adc_i, adc_q, tx_i, tx_q, auto_cal_bits} = stim_q;
  test_and_cca_control_registers #(.CAL_SLOW_PERIOD(100)) uut (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    lag_q <= stim_q;
    stim_q <= stim_q + 23'h0B5A3;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a wait that used up its bound ends the run as a failure
  task automatic give_up(input logic out);
    if (out)
    begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge clk);
    if (pready !== 1'b1)
    begin
      err_count++;
      tally_and_finish;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic dwell;
    @(posedge clk);
    antenna_dwell_interval <= 1'b1;
    @(posedge clk);
    antenna_dwell_interval <= 1'b0;
    @(posedge clk);
  endtask
  // the first tick after a mode change may be short, so time the next one
  task automatic period(input int x);
    int k;
    for (k = 0; k < 5000 && cal_update_tick !== 1'b1; k++) @(posedge clk);
    give_up(k >= 5000);
    @(posedge clk);
    for (k = 1; k < 5000 && cal_update_tick !== 1'b1; k++) @(posedge clk);
    give_up(k >= 5000);
    chk(k, x);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h70, 32'h0);
    rd(8'h78, 32'h0);
    rd(8'h7C, 32'h0);
    apb(1'b1, 8'h70, 32'hA5);
    rd(8'h70, 32'hA5);
    apb(1'b1, 8'h0C, 32'hF6);
    for (int i = 0; i < 2; i++)
    begin
      test_bus_in <= 8'h3C ^ {8{i[0]}};
      apb(1'b1, 8'h74, 32'hFF);
      rd(8'h74, {24'h0, 8'h3C ^ {8{i[0]}}});
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({r[30:0], e}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h78, 32'h1 << i);
      rd(8'h78, 32'h1 << i);
      @(posedge clk);
      t = test_bus_address;
      v = {pn_gen_enable, path_selector_alt, high_rate_xor_to_test_bus, modem_disable,
        adc_raw_pins_enable};
      chk(v, {i == 7, i == 6, i == 5, i == 1, i == 1});
      chk(cal_bits, i == 2 ? 5'h16 : lag_q[4:0]);
      chk(adc_raw_pins, i == 1 ? lag_q[22:11] : 12'h0);
      chk({rx_i, rx_q}, i == 0 ? lag_q[10:5] : lag_q[16:11]);
      @(posedge clk);
      chk(t == test_bus_address, i != 4);
      period(i == 3 ? test_cca_pkg::CAL_FAST_CYCLES : 100);
    end
    apb(1'b1, 8'h7C, 32'hFC);
    rd(8'h7C, 32'hFC);
    raw_channel_clear <= 1'b1;
    dwell;
    chk(channel_clear_assessment, 1'b1);
    raw_channel_clear <= 1'b0;
    repeat (3) @(posedge clk);
    chk(channel_clear_assessment, 1'b1);
    dwell;
    chk(channel_clear_assessment, 1'b0);
    receive_enable <= 1'b1;
    for (n = 0; n < 20 && energy_detect_enable !== 1'b1; n++) @(posedge clk);
    give_up(n >= 20);
    for (n = 0; n < 2000 && energy_detect_enable === 1'b1; n++) @(posedge clk);
    give_up(n >= 2000);
    chk(n, test_cca_pkg::ED_WINDOW_CYCLES);
    apb(1'b1, 8'h7C, 32'h03);
    receive_enable <= 1'b0;
    raw_channel_clear <= 1'b1;
    repeat (5) @(posedge clk);
    chk(energy_detect_enable, 1'b1);
    receive_enable <= 1'b1;
    repeat (5) @(posedge clk);
    dwell;
    chk(energy_detect_update, 1'b1);
    raw_channel_clear <= 1'b0;
    dwell;
    chk(channel_clear_assessment, 1'b1);
    tally_and_finish;
  end
endmodule

// [test_cca_pkg.sv]
// constants for the test and channel assessment control registers
package test_cca_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_TEST_BUS_SELECT = 8'h70;
  localparam logic [7:0] ADDR_TEST_BUS_READBACK = 8'h74;
  localparam logic [7:0] ADDR_TEST_ENABLES_ONE = 8'h78;
  localparam logic [7:0] ADDR_TEST_ENABLES_TWO = 8'h7C;
  localparam logic [7:0] ADDR_CAL_VALUE = 8'h0C;

  // reset values
  localparam logic [7:0] RST_TEST_BUS_SELECT = 8'h00;
  localparam logic [7:0] RST_TEST_ENABLES_ONE = 8'h00;
  localparam logic [7:0] RST_TEST_ENABLES_TWO = 8'h00;
  localparam logic [7:0] RST_CAL_VALUE = 8'h00;
  localparam logic [7:0] RST_LFSR = 8'h01;

  // field positions in test_enables_one
  localparam int BIT_PN_GEN = 7;
  localparam int BIT_PATH_SELECTOR = 6;
  localparam int BIT_HR_XOR = 5;
  localparam int BIT_RANDOM_ADDR = 4;
  localparam int BIT_FAST_CAL = 3;
  localparam int BIT_CAL_OVERRIDE = 2;
  localparam int BIT_ADC_RAW = 1;
  localparam int BIT_LOOPBACK = 0;

  // field positions in test_enables_two
  localparam int BIT_ED_CONTINUOUS = 1;
  localparam int BIT_CCA_SNAPSHOT = 0;

  // calibration value field
  localparam int CAL_BITS = 5;

  // timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ED_WINDOW_NS = 19000;
  localparam int ED_WINDOW_CYCLES = ED_WINDOW_NS / CLK_PERIOD_NS;
  localparam int CAL_SLOW_HZ = 1000;
  localparam int CAL_FAST_HZ = 22000;
  localparam int CAL_SLOW_CYCLES = CLK_HZ / CAL_SLOW_HZ;
  localparam int CAL_FAST_CYCLES = CLK_HZ / CAL_FAST_HZ;

endpackage
